/* File: lhp_host.sv */
// Purpose: host side of an 8-bit strobed parallel panel port, AXI4-Lite slave
// Assumes: 10 MHz aclk, synchronous active-low aresetn, panel data pins async
// Notes:   software queues one byte at a time; panel reset is pulsed after aresetn
//
// What this block does
// - dc low for commands, high for data
// - write strobe low presents a byte
// - read strobe low fetches a byte
// - strobes only while chip select low
// - hold panel reset low at least 3 us
// - wait 10 ms after reset before strobes
// - each transfer moves one byte on eight lines
//
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module lhp_host
	import lhp_pkg::*;
#(
	parameter int RST_WAIT_CYCLES = RST_WAIT_CYC
)
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output lhp_pins_s        pins,
	output logic [7:0]       data_out,
	output logic             data_oe,
	input  wire logic [7:0]  data_in
);

	////////////////////////////////////////////////////////////////////////
	// state
	lhp_state_e      state_ff,   nxt_state;
	logic [CNT_W-1:0] cnt_ff,    nxt_cnt;
	lhp_pins_s       pins_ff,    nxt_pins;
	logic [7:0]      dout_ff,    nxt_dout;
	logic            oe_ff,      nxt_oe;
	logic            is_read_ff, nxt_is_read;
	logic [7:0]      rdata_ff,   nxt_rdata;
	logic            rvld_ff,    nxt_rvld;
	logic            refuse_ff,  nxt_refuse;
	logic            ready_ff,   nxt_ready;
	logic            bvalid_ff,  bresp_err_ff;
	logic            rvalid_ff;
	logic [31:0]     rdout_ff;
	logic            rresp_err_ff;
	logic [7:0]      sync1_ff, sync2_ff, sync3_ff;

	////////////////////////////////////////////////////////////////////////
	// register bus decode
	wire wr_take    = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
	wire rd_take    = s_axi_arvalid && !rvalid_ff;
	wire wr_ctrl    = wr_take && (s_axi_awaddr == OFS_CTRL) && s_axi_wstrb[0];
	wire wr_xfer    = wr_take && (s_axi_awaddr == OFS_XFER) && (s_axi_wstrb[1:0] == 2'h3);
	wire wr_mapped  = (s_axi_awaddr == OFS_CTRL) || (s_axi_awaddr == OFS_XFER);
	wire rd_mapped  = (s_axi_araddr == OFS_CTRL) || (s_axi_araddr == OFS_XFER)
		|| (s_axi_araddr == OFS_STATUS) || (s_axi_araddr == OFS_RDATA);
	wire busy       = (state_ff != ST_IDLE);
	wire rst_req    = wr_ctrl && s_axi_wdata[CTRL_RESET_BIT];
	wire xfer_go    = wr_xfer && !busy && ready_ff;
	wire xfer_bad   = wr_xfer && !xfer_go;
	wire rdata_read = rd_take && (s_axi_araddr == OFS_RDATA);
	wire cnt_zero   = (cnt_ff == '0);
	wire sample_ok  = (sync2_ff == sync3_ff);
	wire [31:0] status_word = {28'h0000000, refuse_ff, rvld_ff, ready_ff, busy};
	wire [31:0] rd_word = (s_axi_araddr == OFS_STATUS) ? status_word
		: (s_axi_araddr == OFS_RDATA) ? {24'h000000, rdata_ff} : 32'h00000000;

	assign s_axi_awready = wr_take;
	assign s_axi_wready  = wr_take;
	assign s_axi_arready = rd_take;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_err_ff ? RESP_SLVERR : RESP_OKAY;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdout_ff;
	assign s_axi_rresp   = rresp_err_ff ? RESP_SLVERR : RESP_OKAY;
	assign pins          = pins_ff;
	assign data_out      = dout_ff;
	assign data_oe       = oe_ff;

	////////////////////////////////////////////////////////////////////////
	// panel sequencer
	always_comb
	begin
		nxt_state   = state_ff;
		nxt_cnt     = cnt_ff;
		nxt_pins    = pins_ff;
		nxt_dout    = dout_ff;
		nxt_oe      = oe_ff;
		nxt_is_read = is_read_ff;
		nxt_rdata   = rdata_ff;
		nxt_ready   = ready_ff;
		// a capture in the same cycle as a data read wins over the clear
		nxt_rvld    = rvld_ff && !rdata_read;
		nxt_refuse  = (refuse_ff && !(wr_ctrl && !s_axi_wdata[CTRL_RESET_BIT])) || xfer_bad;
		case (state_ff)
			ST_RST_LOW:
			begin
				nxt_pins.rst_n = 1'b0;
				if (cnt_zero)
				begin
					nxt_pins.rst_n = 1'b1;
					nxt_cnt        = CNT_W'(RST_WAIT_CYCLES - 1);
					nxt_state      = ST_RST_WAIT;
				end
				else
					nxt_cnt = cnt_ff - 1'b1;
			end
			ST_RST_WAIT:
			begin
				// no strobe moves until the wait has run out
				if (cnt_zero)
				begin
					nxt_ready = 1'b1;
					nxt_state = ST_IDLE;
				end
				else
					nxt_cnt = cnt_ff - 1'b1;
			end
			ST_IDLE:
			begin
				if (rst_req)
				begin
					nxt_ready      = 1'b0;
					nxt_pins.rst_n = 1'b0;
					nxt_cnt        = CNT_W'(RST_LOW_CYC - 1);
					nxt_state      = ST_RST_LOW;
				end
				else if (xfer_go)
				begin
					// select first so dc and data settle before the strobe
					nxt_pins.cs_n                = 1'b0;
					nxt_pins.data_command_select = s_axi_wdata[XFER_DC_BIT];
					nxt_is_read                  = s_axi_wdata[XFER_READ_BIT];
					nxt_dout                     = s_axi_wdata[7:0];
					nxt_oe                       = !s_axi_wdata[XFER_READ_BIT];
					nxt_state                    = ST_SETUP;
				end
			end
			ST_SETUP:
			begin
				if (is_read_ff)
				begin
					nxt_pins.rd_n = 1'b0;
					nxt_cnt       = CNT_W'(RD_LOW_CYC - 1);
					nxt_state     = ST_RD_LOW;
				end
				else
				begin
					nxt_pins.wr_n = 1'b0;
					nxt_state     = ST_WR_LOW;
				end
			end
			ST_WR_LOW:
			begin
				// rising strobe with data still driven gives the latch edge
				nxt_pins.wr_n = 1'b1;
				nxt_state     = ST_HOLD;
			end
			ST_RD_LOW:
			begin
				// wait out access time plus sync delay, then take a stable byte
				if (!cnt_zero)
					nxt_cnt = cnt_ff - 1'b1;
				else if (sample_ok)
				begin
					nxt_rdata     = sync3_ff;
					nxt_rvld      = 1'b1;
					nxt_pins.rd_n = 1'b1;
					nxt_state     = ST_HOLD;
				end
			end
			ST_HOLD:
			begin
				nxt_pins.cs_n = 1'b1;
				nxt_oe        = 1'b0;
				nxt_state     = ST_IDLE;
			end
			default:
			begin
				nxt_pins  = PINS_RST;
				nxt_oe    = 1'b0;
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// sequencer registers; panel reset starts low with every aresetn
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_ff   <= ST_RST_LOW;
			cnt_ff     <= CNT_W'(RST_LOW_CYC - 1);
			pins_ff    <= PINS_RST;
			dout_ff    <= 8'h00;
			oe_ff      <= 1'b0;
			is_read_ff <= 1'b0;
			rdata_ff   <= RDATA_RST;
			rvld_ff    <= 1'b0;
			refuse_ff  <= 1'b0;
			ready_ff   <= 1'b0;
		end
		else
		begin
			state_ff   <= nxt_state;
			cnt_ff     <= nxt_cnt;
			pins_ff    <= nxt_pins;
			dout_ff    <= nxt_dout;
			oe_ff      <= nxt_oe;
			is_read_ff <= nxt_is_read;
			rdata_ff   <= nxt_rdata;
			rvld_ff    <= nxt_rvld;
			refuse_ff  <= nxt_refuse;
			ready_ff   <= nxt_ready;
		end
	end

	// pin data synchroniser; only stage 2 and 3 are compared
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync1_ff <= 8'h00;
			sync2_ff <= 8'h00;
			sync3_ff <= 8'h00;
		end
		else
		begin
			sync1_ff <= data_in;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bus responses
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_ff    <= 1'b0;
			bresp_err_ff <= 1'b0;
			rvalid_ff    <= 1'b0;
			rdout_ff     <= 32'h00000000;
			rresp_err_ff <= 1'b0;
		end
		else
		begin
			if (wr_take)
			begin
				bvalid_ff    <= 1'b1;
				bresp_err_ff <= !wr_mapped;
			end
			else if (s_axi_bready)
				bvalid_ff <= 1'b0;
			if (rd_take)
			begin
				rvalid_ff    <= 1'b1;
				rdout_ff     <= rd_word;
				rresp_err_ff <= !rd_mapped;
			end
			else if (s_axi_rready)
				rvalid_ff <= 1'b0;
		end
	end

endmodule
`default_nettype wire

/* File: lhp_pkg.sv */
// Purpose: constants and types shared by the panel host port controller
// Assumes: 10 MHz aclk, AXI4-Lite with 32-bit data
// Notes:   times are kept in their own unit; cycle counts derive from them
`default_nettype none
package lhp_pkg;
	////////////////////////////////////////////////////////////////////////
	// clock and timing
	localparam int CLK_NS          = 100;
	localparam int T_RST_LOW_NS    = 3000;          // least reset low time
	localparam int T_RST_WAIT_US   = 10000;         // least reset-to-strobe delay
	localparam int T_ACC_NS        = 60;            // read access time
	localparam int RST_LOW_CYC     = (T_RST_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int RST_WAIT_CYC    = (T_RST_WAIT_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int SYNC_STAGES     = 3;
	localparam int RD_LOW_CYC      = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
	localparam int CNT_W           = 17;
	////////////////////////////////////////////////////////////////////////
	// register map (byte addresses)
	localparam logic [3:0] OFS_CTRL   = 4'h0;
	localparam logic [3:0] OFS_XFER   = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h8;
	localparam logic [3:0] OFS_RDATA  = 4'hC;
	// field positions
	localparam int CTRL_RESET_BIT  = 0;
	localparam int XFER_DC_BIT     = 8;
	localparam int XFER_READ_BIT   = 9;
	localparam int STAT_BUSY_BIT   = 0;
	localparam int STAT_READY_BIT  = 1;
	localparam int STAT_RVALID_BIT = 2;
	localparam int STAT_REFUSE_BIT = 3;
	// reset values and responses
	localparam logic [7:0] RDATA_RST  = 8'h00;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	////////////////////////////////////////////////////////////////////////
	// panel pins driven by the host, all active low except dc
	typedef struct packed {
		logic cs_n;
		logic wr_n;
		logic rd_n;
		logic data_command_select;
		logic rst_n;
	} lhp_pins_s;
	localparam lhp_pins_s PINS_RST = '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1,
		data_command_select: 1'b0, rst_n: 1'b0};
	typedef enum logic [2:0] {
		ST_RST_LOW  = 3'b000,
		ST_RST_WAIT = 3'b001,
		ST_IDLE     = 3'b010,
		ST_SETUP    = 3'b011,
		ST_WR_LOW   = 3'b100,
		ST_RD_LOW   = 3'b101,
		ST_HOLD     = 3'b110
	} lhp_state_e;
endpackage
`default_nettype wire

/* File: lhp_host_asserts.sv */
// Purpose: strobe bus checks on the panel side of lhp_host
// Assumes: one clock, bound to lhp_host
// Notes:   reset timing is judged by two small counters
`timescale 1ns/1ps
`default_nettype none
module lhp_host_asserts
	import lhp_pkg::*;
#(
	parameter int RST_WAIT_CYCLES = RST_WAIT_CYC
)
(
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire lhp_pins_s  pins,
	input wire logic [7:0] data_out,
	input wire logic       data_oe
);
	logic [16:0] lo_ff;
	logic [16:0] hi_ff;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////
	// panel reset low and released time; hi saturates so it never wraps
	always_ff @(posedge aclk)
	begin
		lo_ff <= (!aresetn || pins.rst_n) ? 17'h0 : lo_ff + 17'h1;
		// stopping at all ones keeps the full wait count in reach of the check
		hi_ff <= (!aresetn || !pins.rst_n) ? 17'h0 : hi_ff + {16'h0, hi_ff != 17'h1FFFF};
	end
	// lo counts every low cycle and wraps, so a reset held low 29 to 131071 cycles passes here
	AST_RST_LOW: assert property ($rose(pins.rst_n) |-> lo_ff >= 17'h1D)
		else $error("panel reset too short");
	AST_RST_WAIT: assert property ($fell(pins.wr_n) || $fell(pins.rd_n) |-> hi_ff >= RST_WAIT_CYCLES)
		else $error("strobe too soon after reset");
	AST_WR_SEL: assert property (!pins.wr_n |-> !pins.cs_n && data_oe && pins.rd_n)
		else $error("write strobe unselected");
	AST_RD_SEL: assert property (!pins.rd_n |-> !pins.cs_n && !data_oe)
		else $error("read strobe unselected or bus driven");
	AST_CS_SETUP: assert property ($fell(pins.cs_n) |-> pins.wr_n && pins.rd_n)
		else $error("strobe with select edge");
	AST_CS_HOLD: assert property ($rose(pins.cs_n) |-> $past(pins.wr_n) && $past(pins.rd_n))
		else $error("select dropped under strobe");
	AST_DC_HOLD: assert property (!pins.cs_n && !$past(pins.cs_n) |-> $stable(pins.data_command_select))
		else $error("dc moved in transfer");
	AST_DATA_HOLD: assert property ($rose(pins.wr_n) |-> data_oe && $stable(data_out) ##1 $stable(data_out))
		else $error("byte moved at strobe rise");
	cover property ($fell(pins.wr_n) && pins.data_command_select);
	cover property ($fell(pins.rd_n));
	cover property ($rose(pins.rst_n));
endmodule
bind lhp_host lhp_host_asserts #(.RST_WAIT_CYCLES(RST_WAIT_CYCLES)) u_chk (.aclk(aclk),
	.aresetn(aresetn), .pins(pins), .data_out(data_out), .data_oe(data_oe));
`default_nettype wire

/* File: lhp_panel_model.sv */
// Purpose: behavioural panel controller behind the strobe bus
// Assumes: bus level resolved by the bench, no pull on data lines
// Notes:   read data settles ACC_NS after the strobe
`timescale 1ns/1ps
`default_nettype none
module lhp_panel_model
	import lhp_pkg::*;
#(
	parameter int ACC_NS = 60
)
(
	input wire lhp_pins_s  pins,
	input wire logic [7:0] bus,
	output wire logic [7:0] drv
);
	logic [1:0] br, tc, pc;
	logic [2:0] lc;
	logic [7:0] dat;
	////////////////////////////////
	// status byte for commands, last data byte for data
	wire logic sel_rd = !pins.cs_n && !pins.rd_n;
	wire logic [7:0] rv = pins.data_command_select ? dat : {br, tc, pc, lc[2:1]};
	// released bus shows the inverse so a late sample cannot pass by luck
	assign #(ACC_NS) drv = sel_rd ? rv : ~rv;
	// defaults under reset, bytes taken on the strobe rise
	always @(negedge pins.rst_n or posedge pins.wr_n)
	begin
		if (!pins.rst_n)
			{br, tc, pc, lc} = {2'h3, 2'h0, 2'h2, 3'h0};
		else if (!pins.cs_n && pins.data_command_select)
			dat = bus;
		else if (!pins.cs_n)
		begin
			if (bus[7:2] == 6'h3A) br = bus[1:0];
			if (bus[7:2] == 6'h09) tc = bus[1:0];
			if (bus[7:2] == 6'h0A) pc = bus[1:0];
			if (bus[7:3] == 5'h18) lc = bus[2:0];
		end
	end
endmodule
`default_nettype wire

/* File: lhp_host_tb.sv */
// Purpose: register level test of lhp_host against a panel model
// Assumes: 10 MHz aclk, short reset wait parameter
// Notes:   waits end only by the cycle ceiling
`timescale 1ns/1ps
`default_nettype none
module lhp_host_tb;
	import lhp_pkg::*;
	logic        aclk = 1'h0, aresetn = 1'h0;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, data_oe;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [1:0]  bresp_seen, rresp_seen;
	lhp_pins_s   pins;
	logic [7:0]  data_out, data_in, drv;
	int          num_errors = 0, tests_run = 0, cyc = 0;
	assign data_in = data_oe ? data_out : drv;
	lhp_host #(.RST_WAIT_CYCLES(50)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.pins, .data_out, .data_oe, .data_in);
	lhp_panel_model #(.ACC_NS(60)) u_panel (.pins(pins), .bus(data_in), .drv(drv));
	////////////////////////////////
	always #50 aclk = ~aclk;
	// cycle ceiling well above the run length
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			num_errors++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// sampled mid-cycle, so ready is settled before the taking edge
	task automatic await(ref logic s);
		do @(negedge aclk); while (!s);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		await(s_axi_awready);
		@(posedge aclk);
		s_axi_awvalid <= 1'h0;
		s_axi_wvalid <= 1'h0;
		s_axi_bready <= 1'h1;
		await(s_axi_bvalid);
		bresp_seen = s_axi_bresp;
		@(posedge aclk);
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		await(s_axi_arready);
		@(posedge aclk);
		s_axi_arvalid <= 1'h0;
		s_axi_rready <= 1'h1;
		await(s_axi_rvalid);
		v = s_axi_rdata;
		rresp_seen = s_axi_rresp;
		@(posedge aclk);
		s_axi_rready <= 1'h0;
	endtask
	// one panel byte, then poll until idle; reads fetch the byte
	task automatic xfer(input logic r, input logic dc, input logic [7:0] b, output logic [31:0] v);
		wr(OFS_XFER, {22'h0, r, dc, b});
		do rd(OFS_STATUS, v); while (v[STAT_BUSY_BIT]);
		if (r) rd(OFS_RDATA, v);
	endtask
	////////////////////////////////
	initial
	begin
		repeat (5) @(posedge aclk);
		@(negedge aclk) chk({26'h0, data_oe, pins}, {26'h0, 1'h0, PINS_RST});
		@(posedge aclk) aresetn <= 1'h1;
		rd(OFS_STATUS, d);
		chk(d & 32'h2, 32'h0);
		wr(OFS_XFER, 32'h0000_00E9);
		rd(OFS_STATUS, d);
		chk(d & 32'h8, 32'h8);
		wr(OFS_CTRL, 32'h0);
		do rd(OFS_STATUS, d); while (!d[STAT_READY_BIT]);
		chk(d & 32'hB, 32'h2);
		for (int i = 0; i < 4; i++)
		begin
			xfer(1'h0, 1'h0, 8'hE8 | 8'(i), d);
			xfer(1'h0, 1'h0, 8'h24 | 8'(i), d);
			xfer(1'h0, 1'h0, 8'h28 | 8'(i), d);
			xfer(1'h0, 1'h0, 8'hC0 | 8'(i * 2), d);
			xfer(1'h1, 1'h0, 8'h00, d);
			chk(d, {24'h0, {4{i[1:0]}}});
		end
		// a write that lands while a read is under way must be dropped
		xfer(1'h0, 1'h1, 8'hA5, d);
		wr(OFS_XFER, 32'h0000_0300);
		wr(OFS_XFER, 32'h0000_015A);
		do rd(OFS_STATUS, d); while (d[STAT_BUSY_BIT]);
		chk(d & 32'hC, 32'hC);
		rd(OFS_RDATA, d);
		chk(d, 32'hA5);
		rd(OFS_STATUS, d);
		chk(d & 32'hC, 32'h8);
		wr(OFS_CTRL, 32'h0);
		// status is read only, so a write there is answered with an error
		wr(OFS_STATUS, 32'h0);
		chk({30'h0, bresp_seen}, {30'h0, RESP_SLVERR});
		rd(OFS_CTRL, d);
		chk({d[29:0], rresp_seen}, {30'h0, RESP_OKAY});
		// software panel reset brings the panel defaults back
		xfer(1'h0, 1'h0, 8'hE8, d);
		wr(OFS_CTRL, 32'h1);
		rd(OFS_STATUS, d);
		chk(d & 32'h3, 32'h1);
		do rd(OFS_STATUS, d); while (!d[STAT_READY_BIT]);
		xfer(1'h1, 1'h0, 8'h00, d);
		chk(d, 32'hC8);
		xfer(1'h0, 1'h0, 8'hE8, d);
		@(posedge aclk) aresetn <= 1'h0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		do rd(OFS_STATUS, d); while (!d[STAT_READY_BIT]);
		xfer(1'h1, 1'h0, 8'h00, d);
		chk(d, 32'hC8);
		final_report();
	end
endmodule
`default_nettype wire
